//--- logic/sphp_params.svh
// Constants for the strobed parallel host port: widths, status layout and timing counts.
`ifndef SPHP_PARAMS_SVH
`define SPHP_PARAMS_SVH

// Pin bundle carried through the input synchroniser.
`define SPHP_DATA_W 16
`define SPHP_BYTE_W 8
`define SPHP_PIN_W 20
`define SPHP_PIN_CS 19
`define SPHP_PIN_ADDR 18
`define SPHP_PIN_WR 17
`define SPHP_PIN_RD 16
`define SPHP_PIN_DATA_HI 15
`define SPHP_PIN_DATA_LO 0
`define SPHP_PIN_RST_VAL 20'hf0000

// Status word layout.
`define SPHP_STAT_PAGE_HI 15
`define SPHP_STAT_PAGE_LO 8
`define SPHP_STAT_RSVD_W 5
`define SPHP_STAT_RSVD_VAL 5'h00
`define SPHP_STAT_CMD_BIT 2
`define SPHP_STAT_INT_BIT 1
`define SPHP_STAT_WAIT_BIT 0

// Timing of the wait output after a write.
`define SPHP_CLK_PERIOD_NS 25
`define SPHP_WAIT_MAX_NS 280
`define SPHP_WAIT_MAX_CYC ((`SPHP_WAIT_MAX_NS) / (`SPHP_CLK_PERIOD_NS))
`define SPHP_WCNT_W 4
`define SPHP_WCNT_ZERO 4'h0

`define SPHP_WORD_ZERO 16'h0000
`define SPHP_BYTE_ZERO 8'h00

`endif

//--- logic/sphp_pkg.sv
// Types shared by the strobed parallel host port modules.
`default_nettype none
package sphp_pkg;

    typedef enum logic [2:0]
    {
        SPHP_IDLE = 3'b001,
        SPHP_READ = 3'b010,
        SPHP_WRITE = 3'b100
    } sphp_state_e;

    typedef logic [15:0] sphp_word_t;

endpackage

`default_nettype wire

//--- logic/sphp_pin_if.sv
// Interface carrying the raw host pins to the synchroniser and the sampled copies back.
`timescale 1ns/1ps
`default_nettype none
`include "sphp_params.svh"

interface sphp_pin_if;
    logic [`SPHP_PIN_W-1:0] raw;
    logic [`SPHP_PIN_W-1:0] sync;

    modport sampler
    (
        input raw,
        output sync
    );

    modport user
    (
        output raw,
        input sync
    );
endinterface

`default_nettype wire

//--- logic/sphp_sync.sv
// Two-stage synchroniser for the host pins of the parallel host port.
`timescale 1ns/1ps
`default_nettype none
`include "sphp_params.svh"

module sphp_sync
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    sphp_pin_if.sampler pins
);
    logic [`SPHP_PIN_W-1:0] meta_q;
    logic [`SPHP_PIN_W-1:0] meta_d;
    logic [`SPHP_PIN_W-1:0] stable_q;
    logic [`SPHP_PIN_W-1:0] stable_d;

    // The first stage feeds only the second; strobes reset to their idle level.
    always_comb
    begin
        meta_d = pins.raw;
        stable_d = meta_q;
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_q <= `SPHP_PIN_RST_VAL;
            stable_q <= `SPHP_PIN_RST_VAL;
        end
        else
        begin
            meta_q <= meta_d;
            stable_q <= stable_d;
        end
    end

    assign pins.sync = stable_q;
endmodule

`default_nettype wire

//--- logic/sphp_port.sv
// Strobed parallel host port: host strobes in, command and data words out to the core.
`timescale 1ns/1ps
`default_nettype none
`include "sphp_params.svh"

module sphp_port
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic port_select_n_in,
    input wire logic host_cmd_data_in,
    input wire logic host_write_strobe_n_in,
    input wire logic host_read_strobe_n_in,
    input wire logic [15:0] host_data_bus_in,
    output logic [15:0] host_data_bus_out,
    output logic host_data_bus_oe_n_out,
    output logic host_wait_out,
    output logic host_wait_oe_n_out,
    input wire logic cfg_combined_in,
    input wire logic cfg_wide_in,
    input wire logic cfg_swap_in,
    input wire logic cfg_wait_enable_in,
    input wire logic cfg_wait_active_high_in,
    output logic [15:0] word_out,
    output logic word_is_cmd_out,
    output logic word_valid_out,
    output logic cmd_restart_out,
    input wire logic word_accept_in,
    input wire logic cmd_done_in,
    input wire logic read_cmd_in,
    input wire logic [15:0] rd_data_in,
    input wire logic rd_ready_in,
    output logic rd_take_out,
    input wire logic [7:0] active_page_number_in,
    input wire logic irq_level_in
);
    sphp_pin_if pin_bus ();

    assign pin_bus.raw = {port_select_n_in, host_cmd_data_in, host_write_strobe_n_in,
                          host_read_strobe_n_in, host_data_bus_in};

    sphp_sync u_sync
    (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .pins(pin_bus.sampler)
    );

    // Exchanges the two bytes of a word when asked.
    function automatic sphp_pkg::sphp_word_t sphp_swap(input sphp_pkg::sphp_word_t w, input logic en);
        sphp_swap = en ? {w[`SPHP_BYTE_W-1:0], w[`SPHP_DATA_W-1:`SPHP_BYTE_W]} : w;
    endfunction

    // Picks the byte of a word for a narrow read; phase 0 gives the upper byte.
    function automatic logic [7:0] sphp_pick(input sphp_pkg::sphp_word_t w, input logic phase);
        sphp_pick = phase ? w[`SPHP_BYTE_W-1:0] : w[`SPHP_DATA_W-1:`SPHP_BYTE_W];
    endfunction

    logic sel_s;
    logic addr_s;
    logic wr_pin_s;
    logic rd_pin_s;
    logic [15:0] data_s;
    logic rd_act;
    logic wr_act;

    always_comb
    begin
        sel_s = ~pin_bus.sync[`SPHP_PIN_CS];
        addr_s = pin_bus.sync[`SPHP_PIN_ADDR];
        wr_pin_s = pin_bus.sync[`SPHP_PIN_WR];
        rd_pin_s = pin_bus.sync[`SPHP_PIN_RD];
        data_s = pin_bus.sync[`SPHP_PIN_DATA_HI:`SPHP_PIN_DATA_LO];
        if (cfg_combined_in)
        begin
            rd_act = sel_s & ~wr_pin_s & rd_pin_s;
            wr_act = sel_s & ~wr_pin_s & ~rd_pin_s;
        end
        else
        begin
            rd_act = sel_s & ~rd_pin_s;
            wr_act = sel_s & ~wr_pin_s;
        end
    end

    sphp_pkg::sphp_state_e state_q;
    sphp_pkg::sphp_state_e state_d;
    logic acc_addr_q;
    logic acc_addr_d;
    logic [15:0] acc_data_q;
    logic [15:0] acc_data_d;
    logic wr_phase_q;
    logic wr_phase_d;
    logic [7:0] held_byte_q;
    logic [7:0] held_byte_d;
    logic held_addr_q;
    logic held_addr_d;
    logic rd_phase_q;
    logic rd_phase_d;
    logic st_phase_q;
    logic st_phase_d;
    logic cmd_busy_q;
    logic cmd_busy_d;
    logic read_armed_q;
    logic read_armed_d;
    logic post_wr_q;
    logic post_wr_d;
    logic [`SPHP_WCNT_W-1:0] wcnt_q;
    logic [`SPHP_WCNT_W-1:0] wcnt_d;
    logic [15:0] dout_q;
    logic [15:0] dout_d;
    logic drive_q;
    logic drive_d;
    logic wait_lvl_q;
    logic wait_lvl_d;
    logic wait_en_q;
    logic wait_en_d;
    logic [15:0] word_q;
    logic [15:0] word_d;
    logic word_cmd_q;
    logic word_cmd_d;
    logic word_valid_q;
    logic word_valid_d;
    logic restart_q;
    logic restart_d;
    logic take_q;
    logic take_d;

    logic [15:0] status_word;
    logic rd_stall;
    logic [15:0] full_word;
    logic full_addr;
    logic word_done;
    logic as_cmd;

    always_comb
    begin
        status_word = {active_page_number_in, `SPHP_STAT_RSVD_VAL, cmd_busy_q, irq_level_in, wait_lvl_q};
        // A data read stalls until data exists; a status read stalls only after a read command.
        if (acc_addr_q)
        begin
            rd_stall = read_armed_q & ~rd_ready_in;
        end
        else
        begin
            rd_stall = ~rd_ready_in;
        end
        if (cfg_wide_in)
        begin
            full_word = acc_data_q;
            full_addr = acc_addr_q;
            word_done = 1'b1;
        end
        else
        begin
            full_word = {held_byte_q, acc_data_q[`SPHP_BYTE_W-1:0]};
            full_addr = held_addr_q;
            word_done = wr_phase_q;
        end
        as_cmd = full_addr | ~cmd_busy_q;
    end

    always_comb
    begin
        state_d = state_q;
        acc_addr_d = acc_addr_q;
        acc_data_d = acc_data_q;
        wr_phase_d = wr_phase_q;
        held_byte_d = held_byte_q;
        held_addr_d = held_addr_q;
        rd_phase_d = rd_phase_q;
        st_phase_d = st_phase_q;
        cmd_busy_d = cmd_busy_q;
        read_armed_d = read_armed_q | read_cmd_in;
        post_wr_d = post_wr_q;
        wcnt_d = wcnt_q;
        dout_d = dout_q;
        word_d = word_q;
        word_cmd_d = word_cmd_q;
        word_valid_d = 1'b0;
        restart_d = 1'b0;
        take_d = 1'b0;
        wait_en_d = cfg_wait_enable_in;
        if (cmd_done_in)
        begin
            cmd_busy_d = 1'b0;
        end
        // The wait after a write ends when the core takes the word or the limit is reached.
        if (post_wr_q)
        begin
            if (word_accept_in || wcnt_q == `SPHP_WCNT_W'(`SPHP_WAIT_MAX_CYC - 1))
            begin
                post_wr_d = 1'b0;
            end
            wcnt_d = wcnt_q + `SPHP_WCNT_W'(1);
        end
        unique case (state_q)
            sphp_pkg::SPHP_IDLE:
            begin
                acc_addr_d = addr_s;
                acc_data_d = data_s;
                if (rd_act)
                begin
                    state_d = sphp_pkg::SPHP_READ;
                end
                else if (wr_act)
                begin
                    state_d = sphp_pkg::SPHP_WRITE;
                end
            end
            sphp_pkg::SPHP_READ:
            begin
                // Output data is refreshed every cycle so it is valid when wait drops.
                if (acc_addr_q)
                begin
                    if (cfg_wide_in)
                    begin
                        dout_d = status_word;
                    end
                    else
                    begin
                        dout_d = {`SPHP_BYTE_ZERO, sphp_pick(status_word, st_phase_q)};
                    end
                end
                else if (cfg_wide_in)
                begin
                    dout_d = sphp_swap(rd_data_in, cfg_swap_in);
                end
                else
                begin
                    dout_d = {`SPHP_BYTE_ZERO, sphp_pick(rd_data_in, rd_phase_q ^ cfg_swap_in)};
                end
                if (!rd_act)
                begin
                    state_d = sphp_pkg::SPHP_IDLE;
                    if (acc_addr_q)
                    begin
                        st_phase_d = ~st_phase_q & ~cfg_wide_in;
                    end
                    else
                    begin
                        rd_phase_d = ~rd_phase_q & ~cfg_wide_in;
                        read_armed_d = read_cmd_in;
                        take_d = cfg_wide_in | rd_phase_q;
                    end
                end
            end
            sphp_pkg::SPHP_WRITE:
            begin
                // Address and data are followed until the strobe ends, then taken.
                if (wr_act)
                begin
                    acc_addr_d = addr_s;
                    acc_data_d = data_s;
                end
                else
                begin
                    state_d = sphp_pkg::SPHP_IDLE;
                    if (acc_addr_q)
                    begin
                        restart_d = 1'b1;
                        cmd_busy_d = 1'b0;
                        // A read command decoded in the same cycle still arms the stretch.
                        read_armed_d = read_cmd_in;
                        rd_phase_d = 1'b0;
                        st_phase_d = 1'b0;
                    end
                    if (!cfg_wide_in && (!wr_phase_q || acc_addr_q))
                    begin
                        held_byte_d = acc_data_q[`SPHP_BYTE_W-1:0];
                        held_addr_d = acc_addr_q;
                        wr_phase_d = 1'b1;
                    end
                    else if (word_done)
                    begin
                        wr_phase_d = 1'b0;
                        word_valid_d = 1'b1;
                        post_wr_d = 1'b1;
                        wcnt_d = `SPHP_WCNT_ZERO;
                        if (as_cmd)
                        begin
                            word_d = full_word;
                            word_cmd_d = 1'b1;
                            cmd_busy_d = 1'b1;
                        end
                        else
                        begin
                            word_d = sphp_swap(full_word, cfg_swap_in);
                            word_cmd_d = 1'b0;
                        end
                    end
                end
            end
            default:
            begin
                state_d = sphp_pkg::SPHP_IDLE;
            end
        endcase
        // Read data is only fresh one cycle after a read starts, so the bus waits for it and wait covers that cycle.
        drive_d = (state_q == sphp_pkg::SPHP_READ) & (state_d == sphp_pkg::SPHP_READ);
        wait_lvl_d = post_wr_d
            | ((state_d == sphp_pkg::SPHP_READ) & (rd_stall | (state_q != sphp_pkg::SPHP_READ)));
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= sphp_pkg::SPHP_IDLE;
            acc_addr_q <= 1'b0;
            acc_data_q <= `SPHP_WORD_ZERO;
            wr_phase_q <= 1'b0;
            held_byte_q <= `SPHP_BYTE_ZERO;
            held_addr_q <= 1'b0;
            rd_phase_q <= 1'b0;
            st_phase_q <= 1'b0;
            cmd_busy_q <= 1'b0;
            read_armed_q <= 1'b0;
            post_wr_q <= 1'b0;
            wcnt_q <= `SPHP_WCNT_ZERO;
            dout_q <= `SPHP_WORD_ZERO;
            drive_q <= 1'b0;
            wait_lvl_q <= 1'b0;
            wait_en_q <= 1'b0;
            word_q <= `SPHP_WORD_ZERO;
            word_cmd_q <= 1'b0;
            word_valid_q <= 1'b0;
            restart_q <= 1'b0;
            take_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            acc_addr_q <= acc_addr_d;
            acc_data_q <= acc_data_d;
            wr_phase_q <= wr_phase_d;
            held_byte_q <= held_byte_d;
            held_addr_q <= held_addr_d;
            rd_phase_q <= rd_phase_d;
            st_phase_q <= st_phase_d;
            cmd_busy_q <= cmd_busy_d;
            read_armed_q <= read_armed_d;
            post_wr_q <= post_wr_d;
            wcnt_q <= wcnt_d;
            dout_q <= dout_d;
            drive_q <= drive_d;
            wait_lvl_q <= wait_lvl_d;
            wait_en_q <= wait_en_d;
            word_q <= word_d;
            word_cmd_q <= word_cmd_d;
            word_valid_q <= word_valid_d;
            restart_q <= restart_d;
            take_q <= take_d;
        end
    end

    // The wait pin floats until enabled, so an external pull sets the idle level.
    always_comb
    begin
        host_data_bus_out = dout_q;
        host_data_bus_oe_n_out = ~drive_q;
        host_wait_out = cfg_wait_active_high_in ? wait_lvl_q : ~wait_lvl_q;
        host_wait_oe_n_out = ~wait_en_q;
        word_out = word_q;
        word_is_cmd_out = word_cmd_q;
        word_valid_out = word_valid_q;
        cmd_restart_out = restart_q;
        rd_take_out = take_q;
    end
endmodule

`default_nettype wire

//--- tb/sphp_port_assertions.sv
// Concurrent checks on the pins and core pulses of the parallel host port.
`timescale 1ns/1ps
`default_nettype none
module sphp_port_assertions
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic port_select_n_in,
    input wire logic host_cmd_data_in,
    input wire logic host_write_strobe_n_in,
    input wire logic host_read_strobe_n_in,
    input wire logic [15:0] host_data_bus_out,
    input wire logic host_data_bus_oe_n_out,
    input wire logic host_wait_out,
    input wire logic host_wait_oe_n_out,
    input wire logic cfg_combined_in,
    input wire logic cfg_wide_in,
    input wire logic cfg_swap_in,
    input wire logic cfg_wait_enable_in,
    input wire logic cfg_wait_active_high_in,
    input wire logic word_valid_out,
    input wire logic cmd_restart_out,
    input wire logic [15:0] rd_data_in,
    input wire logic rd_ready_in,
    input wire logic rd_take_out
);
    logic rd_act;
    logic busy;
    logic [15:0] rd_exp;
    // The combined scheme reads with the direction line high while the data strobe is low.
    assign rd_act = !port_select_n_in && (cfg_combined_in ? host_read_strobe_n_in && !host_write_strobe_n_in
        : !host_read_strobe_n_in);
    assign busy = !host_wait_oe_n_out && host_wait_out == cfg_wait_active_high_in;
    assign rd_exp = cfg_swap_in ? {rd_data_in[7:0], rd_data_in[15:8]} : rd_data_in;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    // The synchroniser delays the drive, so a few cycles of slack are allowed.
    a_bus_only_read: assert property (
        !host_data_bus_oe_n_out |-> $past(rd_act, 2) || $past(rd_act, 3) || $past(rd_act, 4))
        else $error("bus driven outside a read");
    a_wait_hiz: assert property (
        !cfg_wait_enable_in [*2] |-> host_wait_oe_n_out)
        else $error("wait pin driven while disabled");
    a_restart_addr: assert property (
        cmd_restart_out |-> $past(host_cmd_data_in, 3))
        else $error("restart without address high");
    a_data_read: assert property (
        !host_data_bus_oe_n_out && cfg_wide_in && !busy && !host_cmd_data_in && $past(rd_ready_in)
        && $stable(rd_data_in) |-> host_data_bus_out == $past(rd_exp))
        else $error("read data wrong");
    a_read_nowait: assert property (
        !host_data_bus_oe_n_out && !host_cmd_data_in && rd_ready_in && $past(rd_ready_in)
        && $past(rd_ready_in, 2) |-> !busy)
        else $error("wait active with data ready");
    a_narrow_hi: assert property (
        !host_data_bus_oe_n_out && !cfg_wide_in |-> host_data_bus_out[15:8] == 8'h00)
        else $error("upper lanes used in 8-bit mode");
    a_wait_bound: assert property (
        word_valid_out |-> ##[0:12] !busy)
        else $error("post-write wait too long");
    a_take_after_read: assert property (
        rd_take_out |-> !$past(host_data_bus_oe_n_out) && !$past(host_cmd_data_in, 3))
        else $error("take without data read");

    c_restart: cover property (cmd_restart_out);
    c_take: cover property (rd_take_out);
    c_wait: cover property (busy ##1 !busy);
endmodule

bind sphp_port sphp_port_assertions sphp_port_assertions_inst
(
    .clock_in, .rst_n_in, .port_select_n_in, .host_cmd_data_in, .host_write_strobe_n_in,
    .host_read_strobe_n_in, .host_data_bus_out, .host_data_bus_oe_n_out, .host_wait_out,
    .host_wait_oe_n_out, .cfg_combined_in, .cfg_wide_in, .cfg_swap_in, .cfg_wait_enable_in,
    .cfg_wait_active_high_in, .word_valid_out, .cmd_restart_out, .rd_data_in, .rd_ready_in, .rd_take_out
);
`default_nettype wire

//--- tb/sphp_host.sv
// Host processor model that drives the strobed pins and honours the wait output.
`timescale 1ns/1ps
`default_nettype none
module sphp_host
(
    input wire logic clock_in,
    input wire logic combined_in,
    input wire logic wide_in,
    input wire logic busy_in,
    input wire logic [15:0] bus_in,
    output logic cs_n_out,
    output logic addr_out,
    output logic wr_n_out,
    output logic rd_n_out,
    output logic [15:0] drv_out
);
    initial
    begin
        cs_n_out = 1'b1;
        addr_out = 1'b0;
        wr_n_out = 1'b1;
        rd_n_out = 1'b1;
        drv_out = 16'h5a5a;
    end

    task automatic xfer(input logic a, input logic rd, input logic [15:0] d, output logic [15:0] q);
        int n;
        n = 0;
        while (busy_in === 1'b1 && n < 40)
        begin
            @(negedge clock_in);
            n++;
        end
        addr_out = a;
        cs_n_out = 1'b0;
        if (!rd)
            drv_out = d;
        if (combined_in)
        begin
            rd_n_out = rd;
            wr_n_out = 1'b0;
        end
        else if (rd)
            rd_n_out = 1'b0;
        else
            wr_n_out = 1'b0;
        repeat (6) @(negedge clock_in);
        n = 0;
        while (busy_in === 1'b1 && n < 400)
        begin
            @(negedge clock_in);
            n++;
        end
        q = bus_in;
        cs_n_out = 1'b1;
        wr_n_out = 1'b1;
        rd_n_out = 1'b1;
        // A released bus must not keep showing the last word.
        drv_out = ~drv_out;
        repeat (6) @(negedge clock_in);
    endtask

    task automatic wr_word(input logic a, input logic [15:0] d);
        logic [15:0] q;
        if (wide_in)
            xfer(a, 1'b0, d, q);
        else
        begin
            xfer(a, 1'b0, {8'h00, d[15:8]}, q);
            xfer(1'b0, 1'b0, {8'h00, d[7:0]}, q);
        end
    endtask

    task automatic rd_word(input logic a, output logic [15:0] q);
        logic [15:0] h;
        xfer(a, 1'b1, 16'h0000, h);
        q = h;
        if (!wide_in)
        begin
            xfer(a, 1'b1, 16'h0000, q);
            q = {h[7:0], q[7:0]};
        end
    endtask
endmodule
`default_nettype wire

//--- tb/strobed_parallel_host_port_test.sv
// Self-checking bench for the parallel host port in both strobe schemes.
`timescale 1ns/1ps
`default_nettype none
module strobed_parallel_host_port_test;
    logic clock_in, rst_n_in, port_select_n_in, host_cmd_data_in, host_write_strobe_n_in, host_read_strobe_n_in;
    logic [15:0] host_data_bus_in, host_data_bus_out, drv, word_out, rd_data_in;
    logic host_data_bus_oe_n_out, host_wait_out, host_wait_oe_n_out, word_is_cmd_out, word_valid_out;
    logic cfg_combined_in, cfg_wide_in, cfg_swap_in, cfg_wait_enable_in, cfg_wait_active_high_in;
    logic cmd_restart_out, rd_take_out, irq_level_in, busy;
    logic word_accept_in = 1'b0, cmd_done_in = 1'b0, read_cmd_in = 1'b0, rd_ready_in = 1'b1;
    logic [7:0] active_page_number_in;
    logic [15:0] seed = 16'h41ca;
    logic [16:0] exp_q[$];
    int error_cnt = 0, n_checks = 0, n_rst = 0, n_rst_exp = 0, n_take = 0, n_take_exp = 0;

    assign host_data_bus_in = host_data_bus_oe_n_out ? drv : host_data_bus_out;
    // The wait pin has a pull to its inactive level while undriven.
    assign busy = (host_wait_oe_n_out ? !cfg_wait_active_high_in : host_wait_out) == cfg_wait_active_high_in;

    sphp_port sphp_port_inst
    (
        .clock_in, .rst_n_in, .port_select_n_in, .host_cmd_data_in, .host_write_strobe_n_in,
        .host_read_strobe_n_in, .host_data_bus_in, .host_data_bus_out, .host_data_bus_oe_n_out,
        .host_wait_out, .host_wait_oe_n_out, .cfg_combined_in, .cfg_wide_in, .cfg_swap_in,
        .cfg_wait_enable_in, .cfg_wait_active_high_in, .word_out, .word_is_cmd_out, .word_valid_out,
        .cmd_restart_out, .word_accept_in, .cmd_done_in, .read_cmd_in, .rd_data_in, .rd_ready_in,
        .rd_take_out, .active_page_number_in, .irq_level_in
    );

    sphp_host sphp_host_inst
    (
        .clock_in, .combined_in(cfg_combined_in), .wide_in(cfg_wide_in), .busy_in(busy),
        .bus_in(host_data_bus_in), .cs_n_out(port_select_n_in), .addr_out(host_cmd_data_in),
        .wr_n_out(host_write_strobe_n_in), .rd_n_out(host_read_strobe_n_in), .drv_out(drv)
    );

    initial
    begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end

    function automatic logic [15:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction

    task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic a, input logic [15:0] d, input logic c);
        exp_q.push_back({c, (c || !cfg_swap_in) ? d : {d[7:0], d[15:8]}});
        n_rst_exp += a;
        sphp_host_inst.wr_word(a, d);
    endtask

    // The wait bit is masked since its level depends on the moment of sampling.
    task automatic stat();
        logic [15:0] q;
        sphp_host_inst.rd_word(1'b1, q);
        chk("status", {1'b0, active_page_number_in, 5'h00, 1'b1, irq_level_in, 1'b0}, {1'b0, q[15:1], 1'b0});
    endtask

    always @(negedge clock_in)
    begin
        word_accept_in = word_valid_out === 1'b1;
        if (word_valid_out === 1'b1)
            chk("word", exp_q.size() > 0 ? exp_q.pop_front() : 17'h1ffff, {word_is_cmd_out, word_out});
        n_rst += cmd_restart_out === 1'b1;
        n_take += rd_take_out === 1'b1;
    end

    initial
    begin
        repeat (20000) @(posedge clock_in);
        error_cnt++;
        close_out();
    end

    initial
    begin
        logic [15:0] q;
        logic [15:0] t;
        realtime t0;
        for (int c = 0; c < 2; c++)
        begin
            rst_n_in = 1'b0;
            cfg_combined_in = c[0];
            cfg_wide_in = !c[0];
            cfg_swap_in = !c[0];
            cfg_wait_active_high_in = !c[0];
            cfg_wait_enable_in = 1'b0;
            t = rnd();
            active_page_number_in = t[7:0];
            irq_level_in = t[8];
            rd_data_in = rnd();
            repeat (16) @(negedge clock_in);
            chk("bus_oe_n", 17'h1, {16'h0, host_data_bus_oe_n_out});
            chk("wait_oe_n", 17'h1, {16'h0, host_wait_oe_n_out});
            rst_n_in = 1'b1;
            repeat (4) @(negedge clock_in);
            chk("wait_oe_n", 17'h1, {16'h0, host_wait_oe_n_out});
            cfg_wait_enable_in = 1'b1;
            repeat (2) @(negedge clock_in);
            chk("wait_oe_n", 17'h0, {16'h0, host_wait_oe_n_out});
            wr(1'b1, rnd(), 1'b1);
            stat();
            for (int i = 0; i < 4; i++)
                wr(1'b0, rnd(), 1'b0);
            stat();
            cmd_done_in = 1'b1;
            @(negedge clock_in);
            cmd_done_in = 1'b0;
            wr(1'b0, rnd(), 1'b1);
            read_cmd_in = 1'b1;
            rd_ready_in = 1'b0;
            @(negedge clock_in);
            read_cmd_in = 1'b0;
            t0 = $realtime;
            fork
                stat();
                begin
                    repeat (40) @(negedge clock_in);
                    rd_ready_in = 1'b1;
                end
            join
            chk("stretch", 17'h1, {16'h0, $realtime - t0 >= 1000.0});
            n_take_exp++;
            sphp_host_inst.rd_word(1'b0, q);
            chk("rd_data", {1'b0, cfg_swap_in ? {rd_data_in[7:0], rd_data_in[15:8]} : rd_data_in}, {1'b0, q});
            cmd_done_in = 1'b1;
            @(negedge clock_in);
            cmd_done_in = 1'b0;
        end
        repeat (20) @(negedge clock_in);
        chk("restarts", 17'(n_rst_exp), 17'(n_rst));
        chk("takes", 17'(n_take_exp), 17'(n_take));
        close_out();
    end
endmodule
`default_nettype wire
